//--- core/bfsg_dead_timer.sv
// one phase: never both gates on, and a gap after each turn-off
module bfsg_dead_timer
    import bfsg_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // requested drive
    input wire logic i_req_high,
    input wire logic i_req_low,
    // gate drive
    output logic o_high,
    output logic o_low
);
    logic [1:0] target;
    logic [DEAD_CNT_W-1:0] cnt_q;

    // conflicting requests turn both off rather than shoot through
    assign target = (i_req_high && i_req_low) ? 2'h0 : {i_req_high, i_req_low};

    // off first, wait the dead time, then turn the new side on
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_high <= 1'b0;
            o_low <= 1'b0;
            cnt_q <= '0;
        end else if ({o_high, o_low} != target) begin
            if (o_high || o_low) begin
                o_high <= 1'b0;
                o_low <= 1'b0;
                cnt_q <= DEAD_CNT_W'(DEAD_CYCLES);
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end else begin
                o_high <= target[1];
                o_low <= target[0];
            end
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1; // idle gap still runs out
        end
    end
endmodule

//--- core/bfsg_pkg.sv
package bfsg_pkg;
    // frame layout
    localparam int FRAME_BITS = 16;
    localparam int LONG_FRAME_BITS = 32;
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 12;
    localparam int STORE_BIT = 11;
    localparam int PARITY_BIT = 0;

    // register addresses carried in bits 15..12
    localparam logic [3:0] ADDR_GATE_UV = 4'hC;
    localparam logic [3:0] ADDR_DRAIN_REG = 4'hD;
    localparam logic [3:0] ADDR_SUP_BOOT = 4'hE;
    localparam logic [3:0] ADDR_CONTROL = 4'hF;

    // gate_undervoltage_flags / drain_and_regulator_flags bit positions
    localparam int PH_LO = 1;
    localparam int PH_HI = 4;
    localparam int REG_UNDER_BIT = 9;
    localparam int REG_OVER_BIT = 10;

    // supply_boot_current_flags bit positions
    localparam int OPEN_LOAD_BIT = 1;
    localparam int A_OC_BIT = 2;
    localparam int B_OC_BIT = 3;
    localparam int A_BOOT_BIT = 6;
    localparam int B_BOOT_BIT = 7;
    localparam int SUP_UNDER_BIT = 9;
    localparam int SUP_OVER_BIT = 10;

    // bridge_control bit positions and reset value
    localparam int A_LOW_CMD_BIT = 1;
    localparam int A_HIGH_CMD_BIT = 2;
    localparam int B_LOW_CMD_BIT = 3;
    localparam int B_HIGH_CMD_BIT = 4;
    localparam int HALT_EN_BIT = 7;
    localparam int BOOT_DIS_BIT = 8;
    localparam logic [15:0] CONTROL_RST = 16'h0080;
    localparam logic [15:0] CONTROL_WMASK = 16'h019E;

    // fault_summary bit positions
    localparam int ST_DRAIN_OV = 1;
    localparam int ST_GATE_UV = 2;
    localparam int ST_BOOT_UV = 3;
    localparam int ST_LOAD = 4;
    localparam int ST_REG = 6;
    localparam int ST_WDOG = 7;
    localparam int ST_LOGIC_OV = 8;
    localparam int ST_SUPPLY = 9;
    localparam int ST_HEAT_WARN = 10;
    localparam int ST_THERMAL = 11;
    localparam int ST_FRAME = 13;
    localparam int ST_POWERUP = 14;
    localparam int ST_DIAG_SUM = 15;

    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int DEAD_TIME_NS = 500;
    localparam int DEAD_CYCLES = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_CNT_W = 4;
endpackage

//--- core/bfsg_sync2.sv
// two-stage synchroniser for a vector of asynchronous levels
module bfsg_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // levels
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= RST_VAL;
            o_q <= RST_VAL;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule

//--- core/bfsg_top.sv
// Functional notes
// - every serial frame holds an odd number of ones; bit 0 completes it.
// - word C bits 4..1 latch gate-source undervoltage per switch; read-only.
// - word D holds regulator over/under at 10/9 and drain overvoltage at 4..1.
// - word E holds supply, bootstrap, overcurrent and open-load fault flags.
// - control bits 4..1 drive B high, B low, A high, A low; reset zero.
// - control bit 8 disables the bootstrap manager; reset zero.
// - control bit 7 resets to one and stops the bridge on a fault.
// - status bits 15 and 14 and check bit 0 read one after reset, all others zero.
// - status holds frame, thermal, heat, supply, logic, watchdog and summary flags.
// - supply, regulator, load and bootstrap summaries follow their diagnostic bits.
// - gate and drain summaries follow their four flags; the rest stand alone.
// - each of the four bridge switches has its own control.
// - phase A high input is active high, low input active low.
// - each phase delays turn-on after its partner turns off.
// - phase B high input is active low, opposite to phase A.
module bfsg_top
    import bfsg_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // serial port pins
    input wire logic i_sck,
    input wire logic i_sdi,
    input wire logic i_sel_n,
    output logic o_sdo,
    output logic o_sdo_oe,
    // direct bridge control pins
    input wire logic i_a_high_input,
    input wire logic i_a_low_input_n,
    input wire logic i_b_high_input_n,
    input wire logic i_b_low_input,
    // fault monitors: [3]=b high, [2]=b low, [1]=a high, [0]=a low
    input wire logic [3:0] i_gate_uv,
    input wire logic [3:0] i_drain_ov,
    input wire logic i_reg_over,
    input wire logic i_reg_under,
    input wire logic i_supply_over,
    input wire logic i_supply_under,
    input wire logic i_a_boot_under,
    input wire logic i_b_boot_under,
    input wire logic i_a_overcurrent,
    input wire logic i_b_overcurrent,
    input wire logic i_open_load,
    input wire logic i_thermal_shutdown,
    input wire logic i_heat_warning,
    input wire logic i_logic_over,
    input wire logic i_watchdog_expiry,
    // gate drives and bootstrap manager
    output logic o_a_high_gate,
    output logic o_a_low_gate,
    output logic o_b_high_gate,
    output logic o_b_low_gate,
    output logic o_boot_manager_en
);
    // synchronised pins and serial edge detection
    logic sck_s, sdi_s, sel_n_s;
    logic [3:0] pins_s;
    logic [20:0] mon_s;
    logic sck_prev_q, sel_prev_q;
    logic sck_rise, sck_fall, frame_start, frame_end, active;
    // receive and transmit shifters
    logic [5:0] bit_cnt_q;
    logic [15:0] rx_q, rx_word_q;
    logic rx_par_q;
    logic [31:0] tx_q;
    logic [3:0] read_sel_q;
    logic frame_ok, frame_wr, frame_long;
    // register words and their live sources
    logic [15:0] gate_uv_q, drain_reg_q, sup_boot_q, control_q;
    logic [15:0] gate_uv_live, drain_reg_live, sup_boot_live;
    logic [15:0] status_word, read_word;
    logic frame_fault_q, powerup_q;
    logic [3:0] clr_sel;
    // bridge requests after the stop-on-fail gate
    logic [10:0] halt_faults;
    logic halt, a_hi_req, a_lo_req, b_hi_req, b_lo_req;

    // every pin and monitor level crosses in through two flops
    bfsg_sync2 #(.W(3), .RST_VAL(3'h1)) u_spi_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_d({i_sck, i_sdi, i_sel_n}),
        .o_q({sck_s, sdi_s, sel_n_s})
    );
    // pin copies reset to their idle levels so nothing switches at release
    bfsg_sync2 #(.W(4), .RST_VAL(4'h6)) u_pin_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_d({i_a_high_input, i_a_low_input_n, i_b_high_input_n, i_b_low_input}),
        .o_q(pins_s)
    );
    // monitor order: gate uv, drain ov, regulator, supply, boot, current, status-only
    bfsg_sync2 #(.W(21), .RST_VAL(21'h0)) u_mon_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_d({i_gate_uv, i_drain_ov, i_reg_over, i_reg_under, i_supply_over,
              i_supply_under, i_a_boot_under, i_b_boot_under, i_a_overcurrent,
              i_b_overcurrent, i_open_load, i_thermal_shutdown, i_heat_warning,
              i_logic_over, i_watchdog_expiry}),
        .o_q(mon_s)
    );

    // live fault words laid out as their registers
    always_comb begin
        gate_uv_live = 16'h0000;
        drain_reg_live = 16'h0000;
        sup_boot_live = 16'h0000;
        gate_uv_live[PH_HI:PH_LO] = mon_s[20:17];
        drain_reg_live[PH_HI:PH_LO] = mon_s[16:13];
        drain_reg_live[REG_OVER_BIT] = mon_s[12];
        drain_reg_live[REG_UNDER_BIT] = mon_s[11];
        sup_boot_live[SUP_OVER_BIT] = mon_s[10];
        sup_boot_live[SUP_UNDER_BIT] = mon_s[9];
        sup_boot_live[A_BOOT_BIT] = mon_s[8];
        sup_boot_live[B_BOOT_BIT] = mon_s[7];
        sup_boot_live[A_OC_BIT] = mon_s[6];
        sup_boot_live[B_OC_BIT] = mon_s[5];
        sup_boot_live[OPEN_LOAD_BIT] = mon_s[4];
    end

    // serial pin edges, seen only through the synchronised copies
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sck_prev_q <= 1'b0;
            sel_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            sel_prev_q <= sel_n_s;
        end
    end

    // edges count only inside a frame; a frame ends when select is seen high again
    assign active = ~sel_prev_q && ~sel_n_s;
    assign sck_rise = active && sck_s && ~sck_prev_q;
    assign sck_fall = active && ~sck_s && sck_prev_q;
    assign frame_start = sel_prev_q && ~sel_n_s;
    assign frame_end = ~sel_prev_q && sel_n_s;
    assign frame_long = (bit_cnt_q == 6'(LONG_FRAME_BITS));
    assign frame_ok = ((bit_cnt_q == 6'(FRAME_BITS)) || frame_long) && rx_par_q;
    assign frame_wr = rx_word_q[STORE_BIT];

    // receive: sample on rising clock edges, keep the first sixteen bits
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rx_q <= 16'h0000;
            rx_word_q <= 16'h0000;
            rx_par_q <= 1'b0;
            bit_cnt_q <= 6'h00;
        end else if (frame_start) begin
            rx_q <= 16'h0000;
            rx_word_q <= 16'h0000;
            rx_par_q <= 1'b0;
            bit_cnt_q <= 6'h00;
        end else if (sck_rise) begin
            // every bit of a long frame counts for parity, not only the command
            rx_par_q <= rx_par_q ^ sdi_s;
            rx_q <= {rx_q[14:0], sdi_s};
            if (bit_cnt_q == 6'(FRAME_BITS - 1)) begin
                rx_word_q <= {rx_q[14:0], sdi_s};
            end
            if (bit_cnt_q != 6'h3F) begin
                bit_cnt_q <= bit_cnt_q + 6'h01; // saturates so odd lengths stay bad
            end
        end
    end

    // summary flags follow the latched diagnostic bits
    always_comb begin
        status_word = 16'h0000;
        status_word[ST_DRAIN_OV] = |drain_reg_q[PH_HI:PH_LO];
        status_word[ST_GATE_UV] = |gate_uv_q[PH_HI:PH_LO];
        status_word[ST_BOOT_UV] = sup_boot_q[A_BOOT_BIT] | sup_boot_q[B_BOOT_BIT];
        status_word[ST_LOAD] = sup_boot_q[A_OC_BIT] | sup_boot_q[B_OC_BIT]
                               | sup_boot_q[OPEN_LOAD_BIT];
        status_word[ST_REG] = drain_reg_q[REG_OVER_BIT] | drain_reg_q[REG_UNDER_BIT];
        status_word[ST_SUPPLY] = sup_boot_q[SUP_OVER_BIT] | sup_boot_q[SUP_UNDER_BIT];
        // status-only flags come straight from their synchronised monitors
        status_word[ST_WDOG] = mon_s[0];
        status_word[ST_LOGIC_OV] = mon_s[1];
        status_word[ST_HEAT_WARN] = mon_s[2];
        status_word[ST_THERMAL] = mon_s[3];
        status_word[ST_FRAME] = frame_fault_q;
        status_word[ST_POWERUP] = powerup_q;
        status_word[ST_DIAG_SUM] = |status_word[ST_POWERUP:ST_DRAIN_OV];
        status_word[PARITY_BIT] = ~^status_word[15:1];
    end

    // readback of the word addressed by the previous good frame
    always_comb begin
        case (read_sel_q)
            ADDR_GATE_UV: read_word = gate_uv_q;
            ADDR_DRAIN_REG: read_word = drain_reg_q;
            ADDR_SUP_BOOT: read_word = sup_boot_q;
            default: read_word = control_q;
        endcase
        // even count here, so status plus this word stays odd as a whole
        read_word[PARITY_BIT] = ^read_word[15:1];
    end

    // transmit: status first on every frame, then the addressed word
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_q <= 32'h0000_0000;
            o_sdo <= 1'b0;
            o_sdo_oe <= 1'b0;
        end else begin
            // follows the synchronised select, so it lags the pin by a few clocks
            o_sdo_oe <= ~sel_n_s;
            if (frame_start) begin
                tx_q <= {status_word, read_word};
                o_sdo <= status_word[15];
            end else if (sck_fall) begin
                tx_q <= {tx_q[30:0], 1'b0};
                o_sdo <= tx_q[30];
            end
        end
    end

    // a long frame empties the word it read out; a live fault still wins
    assign clr_sel = (frame_end && frame_ok && frame_long) ? read_sel_q : 4'h0;

    // sticky diagnostic words: a present fault always wins over a readback clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            gate_uv_q <= 16'h0000;
            drain_reg_q <= 16'h0000;
            sup_boot_q <= 16'h0000;
        end else begin
            gate_uv_q <= (clr_sel == ADDR_GATE_UV ? 16'h0000 : gate_uv_q)
                         | gate_uv_live;
            drain_reg_q <= (clr_sel == ADDR_DRAIN_REG ? 16'h0000 : drain_reg_q)
                           | drain_reg_live;
            sup_boot_q <= (clr_sel == ADDR_SUP_BOOT ? 16'h0000 : sup_boot_q)
                          | sup_boot_live;
        end
    end

    // frame bookkeeping; writes to diagnostic words are simply dropped
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            control_q <= CONTROL_RST;
            read_sel_q <= ADDR_CONTROL;
            frame_fault_q <= 1'b0;
            powerup_q <= 1'b1;
        end else if (frame_end) begin
            // only a good frame moves the readback pointer or touches control
            if (frame_ok) begin
                frame_fault_q <= 1'b0;
                powerup_q <= 1'b0;
                read_sel_q <= rx_word_q[ADDR_HI:ADDR_LO];
                if (frame_wr && rx_word_q[ADDR_HI:ADDR_LO] == ADDR_CONTROL) begin
                    control_q <= rx_word_q & CONTROL_WMASK;
                end
            end else begin
                frame_fault_q <= 1'b1;
            end
        end
    end

    // stop on fail ignores the warning-only and frame flags; a cleared fault
    // in word C, D or E still stops the bridge until its sticky word has been read out
    always_comb begin
        halt_faults = status_word[ST_THERMAL:ST_DRAIN_OV];
        halt_faults[ST_HEAT_WARN - ST_DRAIN_OV] = 1'b0; // a warning only reports
    end
    assign halt = control_q[HALT_EN_BIT] && (|halt_faults);

    // pin sense: A high and B low active high, A low and B high active low
    assign a_hi_req = ~halt && (pins_s[3] || control_q[A_HIGH_CMD_BIT]);
    assign a_lo_req = ~halt && (~pins_s[2] || control_q[A_LOW_CMD_BIT]);
    assign b_hi_req = ~halt && (~pins_s[1] || control_q[B_HIGH_CMD_BIT]);
    assign b_lo_req = ~halt && (pins_s[0] || control_q[B_LOW_CMD_BIT]);

    // one dead timer per phase
    bfsg_dead_timer u_phase_a (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_req_high(a_hi_req),
        .i_req_low(a_lo_req),
        .o_high(o_a_high_gate),
        .o_low(o_a_low_gate)
    );
    bfsg_dead_timer u_phase_b (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_req_high(b_hi_req),
        .i_req_low(b_lo_req),
        .o_high(o_b_high_gate),
        .o_low(o_b_low_gate)
    );

    // bootstrap manager runs unless software disables it
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_boot_manager_en <= 1'b1;
        end else begin
            o_boot_manager_en <= ~control_q[BOOT_DIS_BIT];
        end
    end
endmodule

//--- verif/bfsg_host_model.sv
// serial master: one frame at a time, clock idle low between frames
module bfsg_host_model (
    // clock
    input wire logic i_clk,
    // serial pins
    output logic o_sck,
    output logic o_sdi,
    output logic o_sel_n,
    input wire logic i_sdo
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle pins before the first frame
    initial begin
        o_sck = 1'b0;
        o_sdi = 1'b1;
        o_sel_n = 1'b1;
    end
    // n bits msb first, command in the first 16; bad spoils the check bit
    task automatic xfer(input logic [15:0] c, input int n, input bit bad,
        output logic [31:0] rsp);
        logic [31:0] f;
        f = {c[15:1], (~^c[15:1]) ^ bad, 16'h0000};
        rsp = '0;
        @(negedge i_clk);
        o_sel_n = 1'b0;
        repeat (4) @(negedge i_clk);
        for (int k = 31; k >= 32 - n; k--) begin
            o_sdi = f[k];
            repeat (4) @(negedge i_clk);
            o_sck = 1'b1;
            rsp = {rsp[30:0], i_sdo};
            repeat (4) @(negedge i_clk);
            o_sck = 1'b0;
        end
        repeat (4) @(negedge i_clk);
        o_sel_n = 1'b1;
        // a released data line must not look like a held bit
        o_sdi = ~o_sdi;
        repeat (8) @(negedge i_clk);
    endtask
endmodule

//--- verif/bfsg_monitor.sv
// watches the pins of the bridge block: gate exclusion, dead gaps, reply framing
module bfsg_monitor (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // serial pins
    input wire logic i_sck,
    input wire logic i_sel_n,
    input wire logic o_sdo,
    input wire logic o_sdo_oe,
    // bridge drives
    input wire logic o_a_high_gate,
    input wire logic o_a_low_gate,
    input wire logic o_b_high_gate,
    input wire logic o_b_low_gate,
    input wire logic o_boot_manager_en
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // a released gate keeps its partner off for the whole dead time
    sequence s_ah_off; !o_a_high_gate [*5]; endsequence
    sequence s_al_off; !o_a_low_gate [*5]; endsequence
    sequence s_bh_off; !o_b_high_gate [*5]; endsequence
    sequence s_bl_off; !o_b_low_gate [*5]; endsequence
    sequence s_idle; i_sel_n [*6]; endsequence
    property p_a_excl; !(o_a_high_gate && o_a_low_gate); endproperty
    property p_b_excl; !(o_b_high_gate && o_b_low_gate); endproperty
    property p_a_gap_up; $fell(o_a_low_gate) |-> s_ah_off; endproperty
    property p_a_gap_dn; $fell(o_a_high_gate) |-> s_al_off; endproperty
    property p_b_gap_up; $fell(o_b_low_gate) |-> s_bh_off; endproperty
    property p_b_gap_dn; $fell(o_b_high_gate) |-> s_bl_off; endproperty
    // the reply starts a few clocks after select, before the first rising edge
    property p_oe_on; $fell(i_sel_n) |-> ##[1:5] o_sdo_oe; endproperty
    property p_oe_off; s_idle |-> !o_sdo_oe; endproperty
    // shifting only while the serial clock is low keeps the sample window clean
    property p_sdo_low; $changed(o_sdo) |-> !i_sck; endproperty
    property p_rst_val;
        $fell(i_rst) |-> o_boot_manager_en && !o_sdo_oe &&
            !(o_a_high_gate || o_a_low_gate || o_b_high_gate || o_b_low_gate);
    endproperty
    a_a_excl: assert property (p_a_excl) else $error("phase a gates both on");
    a_b_excl: assert property (p_b_excl) else $error("phase b gates both on");
    a_a_gap_up: assert property (p_a_gap_up) else $error("phase a gap short");
    a_a_gap_dn: assert property (p_a_gap_dn) else $error("phase a gap short");
    a_b_gap_up: assert property (p_b_gap_up) else $error("phase b gap short");
    a_b_gap_dn: assert property (p_b_gap_dn) else $error("phase b gap short");
    a_oe_on: assert property (p_oe_on) else $error("reply not driven");
    a_oe_off: assert property (p_oe_off) else $error("reply driven when idle");
    a_sdo_low: assert property (p_sdo_low) else $error("reply moved with clock high");
    a_rst_val: assert property (p_rst_val) else $error("bad value after reset");
endmodule

bind bfsg_top bfsg_monitor u_mon (
    .i_clk(i_clk), .i_rst(i_rst), .i_sck(i_sck), .i_sel_n(i_sel_n), .o_sdo(o_sdo),
    .o_sdo_oe(o_sdo_oe), .o_a_high_gate(o_a_high_gate), .o_a_low_gate(o_a_low_gate),
    .o_b_high_gate(o_b_high_gate), .o_b_low_gate(o_b_low_gate),
    .o_boot_manager_en(o_boot_manager_en)
);

//--- verif/bfsg_tb_top.sv
module bfsg_tb_top
    import bfsg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sck, sdi, sel_n, sdo, sdo_oe, ga_h, ga_l, gb_h, gb_l, boot_en;
    logic a_hi = 1'b0;
    logic a_lo_n = 1'b1;
    logic b_hi_n = 1'b1;
    logic b_lo = 1'b0;
    logic [20:0] flt = '0;
    logic [31:0] rsp;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    // per fault input: diag word (0 = status only), diag bit, status bit
    localparam logic [3:0] FW [21] = '{4'hC, 4'hC, 4'hC, 4'hC, 4'hD, 4'hD, 4'hD, 4'hD,
        4'hD, 4'hD, 4'hE, 4'hE, 4'hE, 4'hE, 4'hE, 4'hE, 4'hE, 4'h0, 4'h0, 4'h0, 4'h0};
    localparam int FB [21] = '{1, 2, 3, 4, 1, 2, 3, 4, 10, 9, 10, 9, 6, 7, 2, 3, 1, 0, 0, 0, 0};
    localparam int FS [21] = '{2, 2, 2, 2, 1, 1, 1, 1, 6, 6, 9, 9, 3, 3, 4, 4, 4, 11, 10, 8, 7};

    bfsg_top DUT (
        .i_clk(clk), .i_rst(rst), .i_sck(sck), .i_sdi(sdi), .i_sel_n(sel_n), .o_sdo(sdo),
        .o_sdo_oe(sdo_oe), .i_a_high_input(a_hi), .i_a_low_input_n(a_lo_n),
        .i_b_high_input_n(b_hi_n), .i_b_low_input(b_lo), .i_gate_uv(flt[3:0]),
        .i_drain_ov(flt[7:4]), .i_reg_over(flt[8]), .i_reg_under(flt[9]),
        .i_supply_over(flt[10]), .i_supply_under(flt[11]), .i_a_boot_under(flt[12]),
        .i_b_boot_under(flt[13]), .i_a_overcurrent(flt[14]), .i_b_overcurrent(flt[15]),
        .i_open_load(flt[16]), .i_thermal_shutdown(flt[17]), .i_heat_warning(flt[18]),
        .i_logic_over(flt[19]), .i_watchdog_expiry(flt[20]), .o_a_high_gate(ga_h),
        .o_a_low_gate(ga_l), .o_b_high_gate(gb_h), .o_b_low_gate(gb_l),
        .o_boot_manager_en(boot_en)
    );
    bfsg_host_model u_host (
        .i_clk(clk), .o_sck(sck), .o_sdi(sdi), .o_sel_n(sel_n), .i_sdo(sdo)
    );

    // word with its odd-count check bit filled in
    function automatic logic [15:0] par(input logic [15:0] w);
        return {w[15:1], ~^w[15:1]};
    endfunction
    // second word of a long reply: even count, so the whole reply stays odd
    function automatic logic [15:0] rd_par(input logic [15:0] w);
        return {w[15:1], ^w[15:1]};
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h got %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        if (mismatches == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic xf(input logic [15:0] c, input int n, input bit bad = 1'b0);
        u_host.xfer(c, n, bad, rsp);
    endtask
    // control write, then time for decode and the dead gap to settle
    task automatic wr(input logic [15:0] v);
        xf({ADDR_CONTROL, 1'b1, v[10:0]}, 16);
        repeat (12) @(negedge clk);
    endtask

    task automatic t_reset();
        check("boot manager", 16'h0001, 16'(boot_en));
        xf({ADDR_CONTROL, 12'h000}, 32);
        check("status", par(16'hC000), rsp[31:16]);
        check("control", rd_par(16'h0080), rsp[15:0]);
        check("reply parity", 16'h0001, 16'(^rsp));
        xf({ADDR_CONTROL, 12'h000}, 16);
        check("status", par(16'h0000), rsp[15:0]);
    endtask
    task automatic t_parity();
        xf({ADDR_CONTROL, 1'b1, 11'h004}, 16, 1'b1);
        repeat (12) @(negedge clk);
        check("bad frame gate", 16'h0000, 16'(ga_h));
        xf({ADDR_CONTROL, 12'h000}, 16);
        check("frame fault", par(16'hA000), rsp[15:0]);
        xf({ADDR_CONTROL, 12'h000}, 16);
        check("fault cleared", par(16'h0000), rsp[15:0]);
    endtask
    task automatic t_ro();
        xf({ADDR_GATE_UV, 1'b1, 11'h01E}, 16);
        xf({ADDR_GATE_UV, 12'h000}, 32);
        check("status first", par(16'h0000), rsp[31:16]);
        check("read-only word", rd_par(16'h0000), rsp[15:0]);
    endtask
    task automatic t_ctrl();
        logic [15:0] v;
        for (int k = 1; k <= 4; k++) begin
            v = 16'h0100 | (16'h0001 << k);
            wr(v);
            check("gate drives", 16'(v[4:1]), 16'({gb_h, gb_l, ga_h, ga_l}));
            check("boot manager", 16'h0000, 16'(boot_en));
            xf({ADDR_CONTROL, 12'h000}, 32);
            check("control", rd_par(v), rsp[15:0]);
        end
    endtask
    task automatic t_halt();
        wr(16'h0084);
        check("a high on", 16'h0001, 16'(ga_h));
        flt[5] = 1'b1;
        flt[18] = 1'b1; // a warning alongside must not lift the stop
        repeat (6) @(negedge clk);
        flt = '0;
        repeat (4) @(negedge clk);
        check("halted", 16'h0000, 16'(ga_h));
        wr(16'h0004);
        check("report only", 16'h0001, 16'(ga_h));
        xf({ADDR_DRAIN_REG, 12'h000}, 16);
        check("status", par(16'h8002), rsp[15:0]);
        xf({ADDR_DRAIN_REG, 12'h000}, 32);
        check("drain word", rd_par(16'h0004), rsp[15:0]);
        wr(16'h0000);
    endtask
    // one pwm line on all four pins: fast decay across the bridge
    task automatic t_pins();
        logic p, d;
        for (int k = 0; k < 4; k++) begin
            p = k[0];
            {a_hi, a_lo_n, b_hi_n, b_lo} = {4{p}};
            repeat (5) @(negedge clk);
            if (k > 0) check("dead gap", 16'h0000, 16'(p ? ga_h : ga_l));
            repeat (10) @(negedge clk);
            check("pwm drive", 16'({p, ~p, ~p, p}), 16'({ga_h, ga_l, gb_h, gb_l}));
        end
        // slow decay: pwm on phase a only, phase b held by the direction line
        for (int k = 0; k < 4; k++) begin
            p = k[0];
            d = k[1];
            {a_hi, a_lo_n, b_hi_n, b_lo} = {p, p, ~d, ~d};
            repeat (15) @(negedge clk);
            check("slow decay", 16'({p, ~p, d, ~d}), 16'({ga_h, ga_l, gb_h, gb_l}));
        end
        {a_hi, a_lo_n, b_hi_n, b_lo} = 4'b0110;
    endtask
    task automatic t_faults();
        logic [15:0] m;
        for (int k = 0; k < 21; k++) begin
            m = 16'h8000 | (16'h0001 << FS[k]);
            flt = 21'h000001 << k;
            repeat (5) @(negedge clk);
            xf({(FW[k] == 4'h0) ? ADDR_CONTROL : FW[k], 12'h000}, 16);
            check("status bits", m, rsp[15:0] & m);
            if (FW[k] != 4'h0) begin
                xf({FW[k], 12'h000}, 32);
                check("diag word", rd_par(16'h0001 << FB[k]), rsp[15:0]);
                flt = '0;
                repeat (4) @(negedge clk);
                xf({FW[k], 12'h000}, 32);
                check("diag latch", rd_par(16'h0001 << FB[k]), rsp[15:0]);
            end
            flt = '0;
        end
    endtask

    // clock, hang guard and main sequence
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        t_reset();
        t_parity();
        t_ro();
        t_ctrl();
        t_halt();
        t_pins();
        t_faults();
        stop_test();
    end
endmodule
